/* dv/tws_master_model.sv */
`timescale 1ns/1ps
module tws_master_model (
  input  wire logic scl_i,      // clock line
  input  wire logic sda_i,      // data line
  output logic      scl_oe_n_o, // low pulls clock
  output logic      sda_oe_n_o  // low pulls data
);
  localparam time HALF = 100;
  initial begin
    scl_oe_n_o = 1'b1;
    sda_oe_n_o = 1'b1;
  end
  task start;
    sda_oe_n_o = 1'b0;
    #HALF scl_oe_n_o = 1'b0;
  endtask
  // data moves an eighth of a bit after the fall so it never looks like a start or stop
  task bit_io(input logic b, output logic s);
    #(HALF / 4) sda_oe_n_o = b;
    #(HALF * 3 / 4) scl_oe_n_o = 1'b1;
    wait (scl_i);
    #HALF s = sda_i;
    scl_oe_n_o = 1'b0;
  endtask
  task send(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask
  task stop;
    #(HALF / 4) sda_oe_n_o = 1'b0;
    #HALF scl_oe_n_o = 1'b1;
    wait (scl_i);
    #HALF sda_oe_n_o = 1'b1;
    #HALF;
  endtask
endmodule

/* dv/tws_slave_rx_properties.sv */
`timescale 1ns/1ps
module tws_slave_rx_properties (
  input wire logic       mclk_i,      // clk
  input wire logic       sys_rst_i,   // rst
  input wire logic       reg_wr_i,    // wr
  input wire logic       reg_rd_i,    // rd
  input wire logic [7:0] reg_rdata_o, // rdata
  input wire logic       scl_i,       // scl
  input wire logic       sda_i,       // sda
  input wire logic       scl_oe_n_o,  // scl hold
  input wire logic       sda_oe_n_o,  // ack
  input wire logic       start_req_o, // start
  input wire logic       wake_o,      // wake
  input wire logic       irq_o        // irq
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  property p_rd; !$past(reg_rd_i) |-> reg_rdata_o == 8'h00; endproperty
  a_rd: assert property (p_rd) else $error("stray read data");
  property p_wk; $fell(wake_o) |-> $past(reg_wr_i, 2) || $past(reg_wr_i, 3); endproperty
  a_wk: assert property (p_wk) else $error("wake dropped");
  property p_rel; $rose(scl_oe_n_o) |-> $past(reg_wr_i, 2) || $past(reg_wr_i, 3); endproperty
  a_rel: assert property (p_rel) else $error("clock hold let go");
  property p_irq; $fell(irq_o) |-> $past(reg_wr_i) || $past(reg_wr_i, 2); endproperty
  a_irq: assert property (p_irq) else $error("irq dropped");
  property p_sp; start_req_o |=> !start_req_o; endproperty
  a_sp: assert property (p_sp) else $error("start not a pulse");
  property p_sf; start_req_o |-> scl_i && sda_i; endproperty
  a_sf: assert property (p_sf) else $error("start on busy bus");
  property p_ack; $fell(sda_oe_n_o) |-> ##[4:40] sda_oe_n_o; endproperty
  a_ack: assert property (p_ack) else $error("ack length");
  property p_wh; $rose(wake_o) |-> ##[0:8] !scl_oe_n_o; endproperty
  a_wh: assert property (p_wh) else $error("no hold on wake");
endmodule
bind tws_slave_rx tws_slave_rx_properties u_props (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .scl_i(scl_i),
  .sda_i(sda_i), .scl_oe_n_o(scl_oe_n_o), .sda_oe_n_o(sda_oe_n_o),
  .start_req_o(start_req_o), .wake_o(wake_o), .irq_o(irq_o));

/* dv/tws_slave_rx_tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin n_errors++; \
  $display("Error %s expected %0h seen %0h", n, e, s); end end
module tws_slave_rx_tb;
  import tws_pkg::*;
  logic       mclk_i = 1'b0;
  logic       sys_rst_i = 1'b1;
  logic       arb_lost_i = 1'b0;
  tws_req_t   rq = '0;
  logic [7:0] reg_rdata_o, d, b;
  logic       scl_oe_n_o, sda_oe_n_o, m_scl_n, m_sda_n, start_req_o, wake_o, irq_o;
  wire        scl = scl_oe_n_o & m_scl_n;
  wire        sda = sda_oe_n_o & m_sda_n;
  int         n_errors = 0, total_checks = 0, cyc = 0, seed = 74939, i;
  logic [6:0] own;
  logic [7:0] ca [7];
  logic [7:0] cst [7];
  always #12.5 mclk_i = ~mclk_i;
  tws_slave_rx uut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .reg_wr_i(rq.wr),
    .reg_rd_i(rq.rd), .reg_addr_i(rq.addr), .reg_wdata_i(rq.wdata),
    .reg_rdata_o(reg_rdata_o), .scl_i(scl), .sda_i(sda), .scl_oe_n_o(scl_oe_n_o),
    .sda_oe_n_o(sda_oe_n_o), .arb_lost_i(arb_lost_i), .start_req_o(start_req_o),
    .wake_o(wake_o), .irq_o(irq_o));
  tws_master_model m (.scl_i(scl), .sda_i(sda), .scl_oe_n_o(m_scl_n), .sda_oe_n_o(m_sda_n));
  function automatic logic [7:0] exp_st(input logic gc, input logic arb);
    if (gc) return arb ? ST_ARB_GC : ST_GC;
    return arb ? ST_ARB_OWN_W : ST_OWN_W;
  endfunction
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge mclk_i) rq <= '{1'b1, 1'b0, a, v};
    @(posedge mclk_i) rq <= '0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge mclk_i) rq <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge mclk_i) rq <= '0;
    @(posedge mclk_i) v = reg_rdata_o;
  endtask
  // one byte from the master, then its ack and the posted status
  task automatic rx(input logic [7:0] v, input logic ax, input logic [7:0] sx);
    logic a;
    m.send(v, a);
    `CHK("ack", ax, a)
    for (int k = 0; k < 20 && sx != ST_IDLE; k++) begin
      rd(REG_CTRL, d);
      if (d[CTL_IFLAG] === 1'b1) break;
    end
    rd(REG_STATUS, d);
    `CHK("status", sx, d)
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      report_and_stop;
    end
  end
  initial begin
    repeat (8) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    rd(REG_CTRL, d); `CHK("ctrl", CTRL_RST, d)
    rd(REG_ADDR, d); `CHK("addr", ADDR_RST, d)
    rd(REG_STATUS, d); `CHK("status", ST_IDLE, d)
    rd(3'h7, d); `CHK("unmapped", ZERO8, d)
    own = 7'h08 + 7'({$random(seed)} % 104);
    wr(REG_ADDR, {own, 1'b1});
    wr(REG_IRQ_MK, 8'h1F);
    wr(REG_CTRL, 8'h44);
    m.start;
    rx({own, 1'b0}, 1'b1, ST_OWN_W);
    `CHK("irq", 1'b1, irq_o)
    for (i = 0; i < 3; i++) begin
      b = 8'($random(seed));
      wr(REG_CTRL, i == 2 ? 8'h84 : 8'hC4);
      rx(b, i < 2, i < 2 ? ST_DATA_ACK : ST_DATA_NACK);
      rd(REG_DATA, d); `CHK("data", b, d)
    end
    wr(REG_CTRL, 8'hE4);
    wr(REG_IRQ_ST, 8'hFF);
    repeat (3) @(negedge mclk_i);
    `CHK("irq", 1'b0, irq_o)
    wr(REG_DATA, 8'h5A);
    rd(REG_CTRL, d); `CHK("wcol", 1'b1, d[CTL_WCOL])
    m.stop;
    for (i = 0; i < 400 && start_req_o !== 1'b1; i++) @(posedge mclk_i);
    `CHK("start", 1'b1, start_req_o)
    // cases: other, read, gc, gc off, ack off, lost own, lost gc
    ca = '{{own + 7'h01, 1'b0}, {own, 1'b1}, 8'h00, 8'h00, {own, 1'b0}, {own, 1'b0}, 8'h00};
    cst = '{ST_IDLE, ST_IDLE, exp_st(1'b1, 1'b0), ST_IDLE, ST_IDLE, exp_st(1'b0, 1'b1),
            exp_st(1'b1, 1'b1)};
    for (i = 0; i < 7; i++) begin
      wr(REG_ADDR, {own, i != 3});
      wr(REG_CTRL, i == 4 ? 8'h04 : 8'h44);
      arb_lost_i <= i > 4;
      m.start;
      rx(ca[i], cst[i] != ST_IDLE, cst[i]);
      arb_lost_i <= 1'b0;
      if (cst[i] != ST_IDLE) wr(REG_CTRL, 8'hC4);
      m.stop;
    end
    wr(REG_IRQ_ST, 8'hFF);
    wr(REG_IRQ_MK, 8'h00);
    wr(REG_PWR, 8'h01);
    m.start;
    rx({own, 1'b0}, 1'b1, ST_OWN_W);
    `CHK("wake", 1'b1, wake_o)
    `CHK("hold", 1'b0, scl_oe_n_o)
    `CHK("irq", 1'b0, irq_o)
    wr(REG_IRQ_MK, 8'h1F);
    repeat (3) @(negedge mclk_i);
    `CHK("irq", 1'b1, irq_o)
    wr(REG_PWR, 8'h00);
    wr(REG_CTRL, 8'hC4);
    wr(REG_IRQ_ST, 8'hFF);
    repeat (3) @(negedge mclk_i);
    `CHK("wake", 1'b0, wake_o)
    `CHK("hold", 1'b1, scl_oe_n_o)
    `CHK("irq", 1'b0, irq_o)
    m.stop;
    report_and_stop;
  end
endmodule

/* rtl/tws_pkg.sv */
package tws_pkg;

  // register indices on the plain register port
  localparam logic [2:0] REG_CTRL   = 3'h0;  // serial_control
  localparam logic [2:0] REG_STATUS = 3'h1;  // serial_status_reg
  localparam logic [2:0] REG_ADDR   = 3'h2;  // own_slave_address
  localparam logic [2:0] REG_DATA   = 3'h3;  // serial_data_reg
  localparam logic [2:0] REG_IRQ_ST = 3'h4;  // sticky event status
  localparam logic [2:0] REG_IRQ_MK = 3'h5;  // event mask
  localparam logic [2:0] REG_PWR    = 3'h6;  // deep sleep control

  // serial_control bit positions
  localparam int CTL_IFLAG = 7;
  localparam int CTL_ACKEN = 6;
  localparam int CTL_START = 5;
  localparam int CTL_STOP  = 4;
  localparam int CTL_WCOL  = 3;
  localparam int CTL_EN    = 2;
  localparam int CTL_IE    = 0;

  localparam int ADR_GCE   = 0;

  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] ADDR_RST  = 8'h00;
  localparam logic [7:0] ZERO8     = 8'h00;
  localparam logic [6:0] GC_ADDR   = 7'h00;

  // slave receiver status codes, prescaler bits zero
  localparam logic [7:0] ST_OWN_W     = 8'h60;
  localparam logic [7:0] ST_ARB_OWN_W = 8'h68;
  localparam logic [7:0] ST_GC        = 8'h70;
  localparam logic [7:0] ST_ARB_GC    = 8'h78;
  localparam logic [7:0] ST_DATA_ACK  = 8'h80;
  localparam logic [7:0] ST_DATA_NACK = 8'h88;
  localparam logic [7:0] ST_IDLE      = 8'hF8;

  // event bits of the sticky status
  localparam int EV_ADDR  = 0;
  localparam int EV_DATA  = 1;
  localparam int EV_NACK  = 2;
  localparam int EV_WAKE  = 3;
  localparam int EV_W     = 4;

  localparam logic [3:0] BIT_LAST = 4'h8;

  typedef enum logic [2:0] {
    TWS_IDLE  = 3'b000,
    TWS_ADDR  = 3'b001,
    TWS_AACK  = 3'b010,
    TWS_DATA  = 3'b011,
    TWS_DACK  = 3'b100,
    TWS_WAIT  = 3'b101,
    TWS_IGN   = 3'b110
  } tws_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } tws_req_t;

endpackage

/* rtl/tws_slave_rx.sv */
`timescale 1ns/1ps
// Functional notes
// - upper seven address bits select this slave
// - address bit zero enables general call
// - address acknowledged only with ack enable
// - write direction enters receiver, read ignored
// - address match sets flag, posts status
// - lost arbitration then addressed reports 68/78
// - cleared ack enable nacks next data byte
// - ack enable low isolates, bus still monitored
// - deep sleep matches address on bus clock
// - wake holds clock low until flag cleared
// - data register may be stale after wake
// - status 60, next byte ack per enable
// - status 70/78, next byte ack per enable
// - status 80, next byte ack per enable
// - status 88 returns to unaddressed slave
// - start request after 88 waits free bus
// - status codes carry zero prescaler bits
module tws_slave_rx
  import tws_pkg::*;
(
  input  wire logic       mclk_i,       // 40 MHz system clock
  input  wire logic       sys_rst_i,    // synchronous reset, active high
  input  wire logic       reg_wr_i,     // register write strobe
  input  wire logic       reg_rd_i,     // register read strobe
  input  wire logic [2:0] reg_addr_i,   // register index
  input  wire logic [7:0] reg_wdata_i,  // write data
  output logic      [7:0] reg_rdata_o,  // read data, cycle after strobe
  input  wire logic       scl_i,        // bus clock pin level
  input  wire logic       sda_i,        // bus data pin level
  output logic            scl_oe_n_o,   // low drives clock pin low
  output logic            sda_oe_n_o,   // low drives data pin low
  input  wire logic       arb_lost_i,   // master side lost arbitration
  output logic            start_req_o,  // master side asked to start
  output logic            wake_o,       // wake request to the part
  output logic            irq_o         // level interrupt
);

  // register-side state
  tws_req_t   req;
  logic [7:0] ctrl_r;
  logic [7:0] addr_r;
  logic [7:0] status_r;
  logic [7:0] data_r;
  logic [4:0] irq_st_r;
  logic [4:0] irq_mk_r;
  logic [4:0] ev;
  logic       pend_start_r;
  logic       sleep_r;
  logic       woke_r;
  // bus-side state
  tws_state_t state_r;
  logic [1:0] scl_sync_r;
  logic [1:0] sda_sync_r;
  logic       scl_d_r;
  logic       sda_d_r;
  logic [7:0] shift_r;
  logic [3:0] bit_cnt_r;
  logic       gc_hit_r;
  logic       arb_r;
  logic       nack_r;
  logic       busy_r;

  assign req = '{wr: reg_wr_i, rd: reg_rd_i, addr: reg_addr_i, wdata: reg_wdata_i};

  // two synchroniser flops plus a delay flop per pin; the second stage and the delay flop feed the edge detectors
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      scl_sync_r <= 2'b11;
      scl_d_r    <= 1'b1;
    end else begin
      scl_sync_r <= {scl_sync_r[0], scl_i};
      scl_d_r    <= scl_sync_r[1];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      sda_sync_r <= 2'b11;
      sda_d_r    <= 1'b1;
    end else begin
      sda_sync_r <= {sda_sync_r[0], sda_i};
      sda_d_r    <= sda_sync_r[1];
    end
  end

  // start and stop need the clock high on both samples, so a data change
  // seen in the same cycle as a clock fall is never taken for a condition
  logic scl_s, sda_s, scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_s     = scl_sync_r[1];
  assign sda_s     = sda_sync_r[1];
  assign scl_rise  = scl_s & ~scl_d_r;
  assign scl_fall  = ~scl_s & scl_d_r;
  assign bus_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign bus_stop  = scl_s & scl_d_r & ~sda_d_r & sda_s;

  function automatic logic sel(input logic [2:0] a, input logic [2:0] r);
    return a == r;
  endfunction

  logic en, acken, iflag;
  assign en    = ctrl_r[CTL_EN];
  assign acken = ctrl_r[CTL_ACKEN];
  assign iflag = ctrl_r[CTL_IFLAG];

  // address match on the completed address byte
  logic own_hit, gc_hit, addr_ok;
  assign own_hit = shift_r[7:1] == addr_r[7:1];
  assign gc_hit  = addr_r[ADR_GCE] & (shift_r[7:1] == GC_ADDR);
  // read direction is left to the transmitter block, not answered here
  assign addr_ok = en & acken & ~shift_r[0] & (own_hit | gc_hit);

  // set-flag requests from the bus engine
  logic set_flag;
  logic [7:0] set_status;

  // bus engine; a stop or a cleared enable drops back to idle from any state
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state_r   <= TWS_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r   <= ZERO8;
      gc_hit_r  <= 1'b0;
      arb_r     <= 1'b0;
      nack_r    <= 1'b0;
    end else if (!en || bus_stop) begin
      state_r   <= TWS_IDLE;
    end else if (bus_start) begin
      state_r   <= TWS_ADDR;   // bus still monitored with ack enable low
      bit_cnt_r <= 4'h0;
      arb_r     <= arb_lost_i;
    end else begin
      case (state_r)
        TWS_ADDR, TWS_DATA: begin
          if (scl_rise) begin
            shift_r   <= {shift_r[6:0], sda_s};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (scl_fall && bit_cnt_r == BIT_LAST) begin
            bit_cnt_r <= 4'h0;
            if (state_r == TWS_ADDR) begin
              gc_hit_r <= gc_hit & ~own_hit;
              state_r  <= addr_ok ? TWS_AACK : TWS_IGN;
            end else begin
              nack_r  <= ~acken;
              state_r <= TWS_DACK;
            end
          end
        end
        TWS_AACK, TWS_DACK: begin
          if (scl_fall) begin
            state_r <= (state_r == TWS_DACK && nack_r) ? TWS_IGN : TWS_WAIT;
          end
        end
        TWS_WAIT: begin
          if (!iflag) begin
            state_r <= TWS_DATA;
          end
        end
        TWS_IDLE, TWS_IGN: state_r <= state_r;
        default: state_r <= TWS_IDLE;
      endcase
    end
  end

  always_comb begin
    set_flag   = 1'b0;
    set_status = ST_IDLE;
    if (en && !bus_start && !bus_stop && scl_fall) begin
      if (state_r == TWS_AACK) begin
        set_flag   = 1'b1;
        set_status = gc_hit_r ? (arb_r ? ST_ARB_GC : ST_GC)
                              : (arb_r ? ST_ARB_OWN_W : ST_OWN_W);
      end else if (state_r == TWS_DACK) begin
        set_flag   = 1'b1;
        set_status = nack_r ? ST_DATA_NACK : ST_DATA_ACK;
      end
    end
  end

  // bus busy between start and stop, for deferred start
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      busy_r <= 1'b0;
    end else if (bus_start) begin
      busy_r <= 1'b1;
    end else if (bus_stop) begin
      busy_r <= 1'b0;
    end
  end

  // a data write while the flag is low is refused and marked as a collision
  logic ctrl_wr;
  assign ctrl_wr = req.wr && sel(req.addr, REG_CTRL);

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ctrl_r <= CTRL_RST;
    end else begin
      if (ctrl_wr) begin
        ctrl_r <= {1'b0, req.wdata[6:4], ctrl_r[CTL_WCOL], req.wdata[2:0]};
        if (req.wdata[CTL_IFLAG]) begin
          ctrl_r[CTL_IFLAG] <= 1'b0;
        end else begin
          ctrl_r[CTL_IFLAG] <= iflag;
        end
      end
      if (set_flag) begin
        ctrl_r[CTL_IFLAG] <= 1'b1;   // set wins over the clear
      end
      if (req.wr && sel(req.addr, REG_DATA) && !iflag) begin
        ctrl_r[CTL_WCOL] <= 1'b1;
      end else if (req.wr && sel(req.addr, REG_DATA)) begin
        ctrl_r[CTL_WCOL] <= 1'b0;
      end
    end
  end

  // start request leaving 0x88 is held until the bus is free
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      pend_start_r <= 1'b0;
    end else if (ctrl_wr && req.wdata[CTL_IFLAG] && req.wdata[CTL_START]
                 && status_r == ST_DATA_NACK) begin
      pend_start_r <= 1'b1;
    end else if (pend_start_r && !busy_r) begin
      pend_start_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      start_req_o <= 1'b0;
    end else begin
      start_req_o <= pend_start_r && !busy_r;
    end
  end

  // status reads the idle code whenever no flag is pending
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      status_r <= ST_IDLE;
    end else if (set_flag) begin
      status_r <= set_status;
    end else if (ctrl_wr && req.wdata[CTL_IFLAG]) begin
      status_r <= ST_IDLE;
    end
  end

  // byte capture; a byte received while asleep is not copied, so the
  // data register may hold an older value after wake
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      data_r <= ZERO8;
    end else if (req.wr && sel(req.addr, REG_DATA) && iflag) begin
      data_r <= req.wdata;
    end else if (set_flag && state_r == TWS_DACK && !sleep_r) begin
      data_r <= shift_r;
    end
  end

  // address register is taken whole; bit zero is the general call enable
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      addr_r <= ADDR_RST;
    end else if (req.wr && sel(req.addr, REG_ADDR)) begin
      addr_r <= req.wdata;
    end
  end

  // deep sleep: address matching stays active from the bus clock edges
  // alone; match raises wake and stretches the clock until flag clears
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      sleep_r <= 1'b0;
    end else if (req.wr && sel(req.addr, REG_PWR)) begin
      sleep_r <= req.wdata[0];
    end else if (set_flag && sleep_r && acken) begin
      sleep_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      woke_r <= 1'b0;
    end else if (set_flag && sleep_r && acken) begin
      woke_r <= 1'b1;
    end else if (!iflag) begin
      woke_r <= 1'b0;
    end
  end

  // bus drivers; data low for ack, clock held low while a flag waits after an acked byte
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      sda_oe_n_o <= 1'b1;
    end else begin
      sda_oe_n_o <= ~((state_r == TWS_AACK) | (state_r == TWS_DACK & ~nack_r));
    end
  end

  // stretch while a flag waits after an acked address or data byte, or from wake until cleared
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      scl_oe_n_o <= 1'b1;
    end else begin
      scl_oe_n_o <= ~((state_r == TWS_WAIT & ~scl_s) | woke_r);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      wake_o <= 1'b0;
    end else begin
      wake_o <= woke_r;
    end
  end

  // event bits, lowest first: flag, address, data ack, nack, wake
  assign ev = {
    set_flag & sleep_r,
    set_flag & (set_status == ST_DATA_NACK),
    set_flag & (set_status == ST_DATA_ACK),
    set_flag & (state_r == TWS_AACK),
    set_flag & ~sleep_r
  };

  // cleared by writing ones; an event in the same cycle still lands
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      irq_st_r <= '0;
    end else if (req.wr && sel(req.addr, REG_IRQ_ST)) begin
      irq_st_r <= (irq_st_r & ~req.wdata[EV_W-1+1:0]) | ev;
    end else begin
      irq_st_r <= irq_st_r | ev;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      irq_mk_r <= '0;
    end else if (req.wr && sel(req.addr, REG_IRQ_MK)) begin
      irq_mk_r <= req.wdata[EV_W:0];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_st_r & irq_mk_r) | (iflag & ctrl_r[CTL_IE]);
    end
  end

  // read data stand one cycle only and are zero otherwise, so a stale
  // value is never taken for a fresh read

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= ZERO8;
    end else if (req.rd) begin
      case (req.addr)
        REG_CTRL:   reg_rdata_o <= ctrl_r;
        REG_STATUS: reg_rdata_o <= status_r;
        REG_ADDR:   reg_rdata_o <= addr_r;
        REG_DATA:   reg_rdata_o <= data_r;
        REG_IRQ_ST: reg_rdata_o <= {3'h0, irq_st_r};
        REG_IRQ_MK: reg_rdata_o <= {3'h0, irq_mk_r};
        REG_PWR:    reg_rdata_o <= {7'h00, sleep_r};
        default:    reg_rdata_o <= ZERO8;
      endcase
    end else begin
      reg_rdata_o <= ZERO8;
    end
  end

endmodule
